// file: rtl/fpv_pkg.sv
// Purpose: shared constants and types for the preemption verify and statistics block
// Assumes: one port MAC clock, synchronous active-high reset
// Notes:   counters are per port; one instance of the block serves one port
package fpv_pkg;
  localparam logic [7:0]  FPV_CODE_VERIFY  = 8'h07;
  localparam logic [7:0]  FPV_CODE_RESPOND = 8'h19;
  localparam logic [1:0]  FPV_MAX_TRIES    = 2'h3;
  localparam int          FPV_CNT_W        = 32;
  localparam logic [31:0] FPV_CNT_MAX      = 32'hffffffff;
  localparam logic [31:0] FPV_CNT_ONE      = 32'h00000001;
  localparam logic [31:0] FPV_CNT_ZERO     = 32'h00000000;
  localparam int          FPV_NUM_CNT      = 6;
  localparam logic [2:0]  FPV_CNT_ASM_ERR  = 3'h0;
  localparam logic [2:0]  FPV_CNT_SMD_ERR  = 3'h1;
  localparam logic [2:0]  FPV_CNT_ASM_OK   = 3'h2;
  localparam logic [2:0]  FPV_CNT_FRAG_RX  = 3'h3;
  localparam logic [2:0]  FPV_CNT_FRAG_TX  = 3'h4;
  localparam logic [2:0]  FPV_CNT_HOLD     = 3'h5;
  localparam logic [15:0] FPV_CRC_XOR      = 16'hffff;
  localparam logic [8:0]  FPV_FRAG_UNIT    = 9'h040;
  localparam logic [23:0] FPV_TMO_DEFAULT  = 24'h00f424;
  localparam logic [23:0] FPV_TMO_ONE      = 24'h000001;
  localparam logic [23:0] FPV_TMO_ZERO     = 24'h000000;
  localparam logic [1:0]  FPV_TRY_ONE      = 2'h1;
  localparam logic [1:0]  FPV_TRY_ZERO     = 2'h0;

  // advertised capability: supported, enabled, active
  typedef struct packed {
    logic supported;
    logic enabled;
    logic active;
  } fpv_adv_type;

  typedef enum logic [2:0] {
    FPV_IDLE,
    FPV_ADVERT,
    FPV_VERIFY,
    FPV_WAIT,
    FPV_ACTIVE,
    FPV_FAILED,
    FPV_FORCED
  } fpv_state_type;

  // non-final fragment size code 0..3 -> 64,128,192,256 bytes
  function automatic logic [8:0] fpv_frag_bytes(input logic [1:0] code);
    fpv_frag_bytes = 9'(({7'h00, code} + 9'h001) * FPV_FRAG_UNIT);
  endfunction

  function automatic logic [31:0] fpv_sat_inc(input logic [31:0] v);
    fpv_sat_inc = (v == FPV_CNT_MAX) ? v : v + FPV_CNT_ONE;
  endfunction
endpackage

// file: rtl/fpv_port.sv
// Purpose: per-port preemption discovery, verify handshake, force mode and statistics
// Assumes: inputs synchronous to i_core_clk; MAC raises one-cycle event strobes
// Notes:   verify codes go out through a two-entry buffer so a stalled MAC loses none
//
// Behaviour
// R1: with preemption enabled, first advertise supported only.
// R2: without partner support advertised, keep preemption disabled and inactive.
// R3: partner supports and verify on: advertise supported+enabled, send verify code 0x07.
// R4: respond code 0x19 received: advertise all three, transmit preemptable traffic.
// R5: no respond before timeout: send another verify.
// R6: after three unanswered verifies stop and advertise supported only.
// R7: force mode skips verify, advertises all three, sends preemptable traffic.
// R8: software should use force mode only for debugging.
// R9: non-final fragment minimum selectable as 64, 128, 192 or 256 bytes.
// R10: each statistics counter clears when read.
// R11: each statistics counter saturates instead of wrapping.
// R12: count frames reassembled with error.
// R13: count frames with invalid start delimiter code.
// R14: count frames reassembled correctly.
// R15: count valid continuation fragments received.
// R16: count fragments transmitted.
// R17: count hold request assertions.
// R18: receiver always accepts start and continuation fragments.
// R19: non-final fragment check value has 16 bits inverted; final one unmodified.
// R20: verify timeout configurable, restarted at every verify sent.
// R21: counters are 32 bits, one set per port.
`timescale 1ns/10ps
module fpv_port
  import fpv_pkg::*;
(
  // clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_reset,
  // configuration
  input  wire logic                 i_preempt_en,
  input  wire logic                 i_verify_en,
  input  wire logic                 i_force_en,
  input  wire logic [23:0]          i_verify_timeout,
  input  wire logic [1:0]           i_min_frag_code,
  // link discovery and handshake from receive MAC
  input  wire logic                 i_partner_adv_valid,
  input  wire logic                 i_partner_supports,
  input  wire logic                 i_rx_code_valid,
  input  wire logic [7:0]           i_rx_code,
  // verify transmit path toward MAC
  output logic                      o_tx_code_valid,
  output logic [7:0]                o_tx_code,
  input  wire logic                 i_tx_code_ready,
  // fragment check value
  input  wire logic [31:0]          i_tx_crc,
  input  wire logic                 i_tx_frag_last,
  output logic [31:0]               o_tx_mcrc,
  // status
  output logic                      o_adv_supported,
  output logic                      o_adv_enabled,
  output logic                      o_adv_active,
  output logic                      o_preempt_tx_on,
  output logic                      o_rx_preempt_accept,
  output logic [8:0]                o_min_frag_bytes,
  // statistics events
  input  wire logic                 i_ev_asm_err,
  input  wire logic                 i_ev_smd_err,
  input  wire logic                 i_ev_asm_ok,
  input  wire logic                 i_ev_frag_rx,
  input  wire logic                 i_ev_frag_tx,
  input  wire logic                 i_ev_hold,
  // statistics read port
  input  wire logic                 i_cnt_rd,
  input  wire logic [2:0]           i_cnt_sel,
  output logic [FPV_CNT_W-1:0]      o_cnt_data
);

  fpv_state_type state_q, state_d;
  logic [23:0]   timer_q, timer_d;
  logic [1:0]    tries_q, tries_d;
  logic          partner_q, partner_d;
  logic          send_verify;
  fpv_adv_type   adv_d;

  // two-entry buffer for verify codes
  logic [7:0]    buf_q [2];
  logic [1:0]    cnt_q;
  logic          rd_q;
  logic          wr_q;
  wire logic     buf_full  = (cnt_q == 2'h2);
  wire logic     buf_empty = (cnt_q == 2'h0);
  wire logic     push      = send_verify & ~buf_full;
  wire logic     pop       = o_tx_code_valid & i_tx_code_ready;

  wire logic     got_respond = i_rx_code_valid & (i_rx_code == FPV_CODE_RESPOND);
  wire logic     timed_out   = (timer_q == FPV_TMO_ZERO);
  wire logic [23:0] tmo_load = (i_verify_timeout == FPV_TMO_ZERO) ? FPV_TMO_ONE
                                                                  : i_verify_timeout;

  // partner capability as last seen in discovery
  always_comb begin
    partner_d = partner_q;
    if (!i_preempt_en) begin
      partner_d = 1'b0;
    end else if (i_partner_adv_valid) begin
      partner_d = i_partner_supports;
    end
  end

  always_comb begin
    state_d     = state_q;
    timer_d     = timer_q;
    tries_d     = tries_q;
    send_verify = 1'b0;
    unique case (state_q)
      FPV_IDLE: begin
        if (i_preempt_en) begin
          state_d = i_force_en ? FPV_FORCED : FPV_ADVERT;
        end
      end
      FPV_ADVERT: begin
        if (partner_q && i_verify_en) begin                  // R3
          state_d = FPV_VERIFY;
          tries_d = FPV_TRY_ZERO;
        end
      end
      FPV_VERIFY: begin
        // wait for buffer room; the verify is never silently dropped
        if (!buf_full) begin
          send_verify = 1'b1;                               // R3 R5
          tries_d     = tries_q + FPV_TRY_ONE;
          timer_d     = tmo_load;                           // R20
          state_d     = FPV_WAIT;
        end
      end
      FPV_WAIT: begin
        if (got_respond) begin
          state_d = FPV_ACTIVE;                             // R4
        end else if (timed_out) begin
          state_d = (tries_q == FPV_MAX_TRIES) ? FPV_FAILED : FPV_VERIFY; // R5 R6
        end else begin
          timer_d = timer_q - FPV_TMO_ONE;
        end
      end
      FPV_ACTIVE: begin
      end
      FPV_FAILED: begin
      end
      FPV_FORCED: begin
      end
    endcase
    // leaving force mode, or losing the partner outside force mode, restarts discovery
    if (!i_preempt_en || (state_q == FPV_FORCED && !i_force_en)) begin
      state_d = FPV_IDLE;
    end else if (i_force_en && state_q != FPV_FORCED) begin
      state_d = FPV_FORCED;                                 // R7
    end else if (!partner_q && state_q != FPV_FORCED && state_q != FPV_IDLE) begin
      state_d = FPV_ADVERT;                                 // R2
    end
  end

  always_comb begin
    adv_d = '{supported: 1'b0, enabled: 1'b0, active: 1'b0};
    unique case (state_d)
      FPV_IDLE:   adv_d = '{supported: 1'b0, enabled: 1'b0, active: 1'b0};
      FPV_ADVERT: adv_d = '{supported: 1'b1, enabled: 1'b0, active: 1'b0}; // R1 R2
      FPV_VERIFY: adv_d = '{supported: 1'b1, enabled: 1'b1, active: 1'b0}; // R3
      FPV_WAIT:   adv_d = '{supported: 1'b1, enabled: 1'b1, active: 1'b0}; // R3
      FPV_ACTIVE: adv_d = '{supported: 1'b1, enabled: 1'b1, active: 1'b1}; // R4
      FPV_FAILED: adv_d = '{supported: 1'b1, enabled: 1'b0, active: 1'b0}; // R6
      FPV_FORCED: adv_d = '{supported: 1'b1, enabled: 1'b1, active: 1'b1}; // R7
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_q   <= FPV_IDLE;
      timer_q   <= FPV_TMO_ZERO;
      tries_q   <= FPV_TRY_ZERO;
      partner_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      timer_q   <= timer_d;
      tries_q   <= tries_d;
      partner_q <= partner_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_adv_supported     <= 1'b0;
      o_adv_enabled       <= 1'b0;
      o_adv_active        <= 1'b0;
      o_preempt_tx_on     <= 1'b0;
      o_rx_preempt_accept <= 1'b0;
      o_min_frag_bytes    <= fpv_frag_bytes(2'h0);
      o_tx_mcrc           <= FPV_CNT_ZERO;
    end else begin
      o_adv_supported     <= adv_d.supported;
      o_adv_enabled       <= adv_d.enabled;
      o_adv_active        <= adv_d.active;
      o_preempt_tx_on     <= adv_d.active;                  // R4 R7
      o_rx_preempt_accept <= 1'b1;                          // R18
      o_min_frag_bytes    <= fpv_frag_bytes(i_min_frag_code); // R9
      o_tx_mcrc           <= i_tx_frag_last ? i_tx_crc
                                            : {i_tx_crc[31:16], i_tx_crc[15:0] ^ FPV_CRC_XOR}; // R19
    end
  end

  // verify code buffer; head always at entry rd_q
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt_q <= 2'h0;
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
    end else begin
      if (push) begin
        buf_q[wr_q] <= FPV_CODE_VERIFY;                     // R3
        wr_q        <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_tx_code_valid <= 1'b0;
      o_tx_code       <= 8'h00;
    end else if (!o_tx_code_valid || pop) begin
      // registered head; next entry becomes visible the cycle after pop
      o_tx_code_valid <= !buf_empty && !(pop && cnt_q == 2'h1);
      o_tx_code       <= pop ? buf_q[~rd_q] : buf_q[rd_q];
    end
  end

  // statistics
  logic [FPV_CNT_W-1:0] stat_q [FPV_NUM_CNT];
  wire logic [FPV_NUM_CNT-1:0] ev = {i_ev_hold, i_ev_frag_tx, i_ev_frag_rx,
                                     i_ev_asm_ok, i_ev_smd_err, i_ev_asm_err}; // R12 R13 R14 R15 R16 R17

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      for (int i = 0; i < FPV_NUM_CNT; i++) begin
        stat_q[i] <= FPV_CNT_ZERO;
      end
      o_cnt_data <= FPV_CNT_ZERO;
    end else begin
      for (int i = 0; i < FPV_NUM_CNT; i++) begin
        if (i_cnt_rd && i_cnt_sel == 3'(i)) begin
          // an event in the read cycle is kept, not lost
          stat_q[i] <= ev[i] ? FPV_CNT_ONE : FPV_CNT_ZERO;  // R10
        end else if (ev[i]) begin
          stat_q[i] <= fpv_sat_inc(stat_q[i]);              // R11 R21
        end
      end
      if (i_cnt_rd) begin
        o_cnt_data <= (i_cnt_sel < 3'(FPV_NUM_CNT)) ? stat_q[i_cnt_sel] : FPV_CNT_ZERO;
      end
    end
  end

endmodule

// file: dv/fpv_mac_model.sv
// Purpose: link partner MAC on the verify path of one port
// Assumes: bench sets stall and answer levels
// Notes:   idle code bus shows a changing pattern, not the last code
`timescale 1ns/10ps
module fpv_mac_model (
  // clock
  input  wire logic       i_core_clk,
  // verify path
  input  wire logic       i_code_valid,
  input  wire logic       i_stall,
  input  wire logic       i_answer,
  output logic            o_code_ready,
  output logic            o_resp_valid,
  output logic [7:0]      o_resp_code
);
  wire logic take = i_code_valid && o_code_ready && i_answer;
  initial begin
    o_code_ready = 1'b0;
    o_resp_valid = 1'b0;
    o_resp_code  = 8'h00;
  end
  always @(posedge i_core_clk) begin
    o_code_ready <= !i_stall;
    o_resp_valid <= take;
    o_resp_code  <= take ? 8'h19 : ~o_resp_code;
  end
endmodule

// file: dv/fpv_port_chk.sv
// Purpose: port-level checks for the preemption verify block
// Assumes: one clock, synchronous reset
// Notes:   counter saturation is too deep to reach here
`timescale 1ns/10ps
module fpv_port_chk
  import fpv_pkg::*;
(
  // clock, reset and configuration
  input wire logic i_core_clk, i_reset, i_preempt_en, i_force_en,
  input wire logic [1:0] i_min_frag_code,
  // verify path and check value
  input wire logic i_tx_code_ready, i_tx_frag_last, o_tx_code_valid,
  input wire logic [7:0] o_tx_code,
  input wire logic [31:0] i_tx_crc, o_tx_mcrc,
  // status and counters
  input wire logic o_adv_supported, o_adv_enabled, o_adv_active, o_rx_preempt_accept,
  input wire logic [8:0] o_min_frag_bytes,
  input wire logic i_cnt_rd,
  input wire logic [2:0] i_cnt_sel,
  input wire logic [31:0] o_cnt_data
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  frag_size_a: assert property (
    $past(!i_reset) |-> o_min_frag_bytes == {1'b0, $past(i_min_frag_code), 6'h00} + 9'h040)
    else $error("fragment size wrong");
  crc_last_a: assert property (
    i_tx_frag_last |=> o_tx_mcrc == $past(i_tx_crc)) else $error("final crc altered");
  crc_frag_a: assert property (
    !i_tx_frag_last |=> o_tx_mcrc == ($past(i_tx_crc) ^ 32'h0000ffff))
    else $error("fragment crc wrong");
  rx_accept_a: assert property (
    $past(!i_reset) |-> o_rx_preempt_accept) else $error("receive not accepting");
  adv_idle_a: assert property (
    !i_preempt_en |=> !(o_adv_supported | o_adv_enabled | o_adv_active))
    else $error("advertising while off");
  adv_order_a: assert property (
    o_adv_active |-> o_adv_enabled && o_adv_supported) else $error("active without enabled");
  code_value_a: assert property (
    o_tx_code_valid |-> o_tx_code == 8'h07) else $error("verify code wrong");
  code_hold_a: assert property (
    o_tx_code_valid && !i_tx_code_ready |=> o_tx_code_valid) else $error("code dropped");
  force_on_a: assert property (
    $rose(i_force_en) && i_preempt_en |-> ##[1:3] (o_adv_enabled && o_adv_active))
    else $error("force not active");
  bad_sel_a: assert property (
    i_cnt_rd && i_cnt_sel > 3'h5 |=> o_cnt_data == 32'h0) else $error("bad select read");
  read_clear_a: assert property (
    i_cnt_rd ##1 (i_cnt_rd && $stable(i_cnt_sel)) |=> o_cnt_data <= 32'h1)
    else $error("read did not clear");
  cover property (o_adv_active && !i_force_en);
  cover property (o_tx_code_valid && !i_tx_code_ready);
  cover property (i_cnt_rd ##1 i_cnt_rd);
endmodule
bind fpv_port fpv_port_chk u_chk (.*);

// file: dv/frame_preemption_verify_stats_bench.sv
// Purpose: self-checking bench for one preemption port
// Assumes: verify timeout shortened to 8 cycles
// Notes:   partner model answers verifies when told to
`timescale 1ns/10ps
module frame_preemption_verify_stats_bench;
  import fpv_pkg::*;
  logic i_core_clk = 1'b0, i_reset = 1'b1, i_preempt_en = 1'b0, i_verify_en = 1'b1;
  logic i_force_en = 1'b0, i_partner_adv_valid = 1'b0, i_partner_supports = 1'b0;
  logic i_tx_frag_last = 1'b0, i_cnt_rd = 1'b0, stall = 1'b0, answer = 1'b0;
  logic [23:0] i_verify_timeout = 24'h000008;
  logic [1:0] i_min_frag_code = 2'h0;
  logic [2:0] i_cnt_sel = 3'h0;
  logic [31:0] i_tx_crc = 32'h0, o_tx_mcrc, o_cnt_data;
  logic [5:0] ev = 6'h00;
  logic [8:0] o_min_frag_bytes;
  logic [7:0] o_tx_code, i_rx_code;
  logic o_tx_code_valid, i_tx_code_ready, i_rx_code_valid, o_rx_preempt_accept;
  logic o_adv_supported, o_adv_enabled, o_adv_active, o_preempt_tx_on;
  wire logic i_ev_asm_err, i_ev_smd_err, i_ev_asm_ok, i_ev_frag_rx, i_ev_frag_tx, i_ev_hold;
  int err_total = 0, check_count = 0, cyc = 0, takes = 0;
  assign {i_ev_hold, i_ev_frag_tx, i_ev_frag_rx, i_ev_asm_ok, i_ev_smd_err, i_ev_asm_err} = ev;
  fpv_port u_dut (.*);
  fpv_mac_model u_mac (.i_core_clk(i_core_clk), .i_code_valid(o_tx_code_valid),
    .i_stall(stall), .i_answer(answer), .o_code_ready(i_tx_code_ready),
    .o_resp_valid(i_rx_code_valid), .o_resp_code(i_rx_code));
  initial forever #4 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (o_tx_code_valid && i_tx_code_ready) takes <= takes + 1;
    if (cyc == 3000) begin
      err_total++;
      conclude();
    end
  end
  task automatic conclude();
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // drop enable so the silent, verify and retry scenarios start from idle
  task automatic restart(input logic s);
    i_preempt_en <= 1'b0;
    i_force_en <= 1'b0;
    tick(3);
    takes = 0;
    i_preempt_en <= 1'b1;
    i_partner_supports <= s;
    i_partner_adv_valid <= 1'b1;
    tick(1);
    i_partner_adv_valid <= 1'b0;
  endtask
  task automatic rd_cnt(input logic [2:0] s, input int n);
    i_cnt_rd <= 1'b1;
    i_cnt_sel <= s;
    tick(n);
    i_cnt_rd <= 1'b0;
    tick(1);
  endtask
  task automatic t_force();
    i_force_en <= 1'b1;
    tick(4);
    chk({o_adv_supported, o_adv_enabled, o_adv_active, o_preempt_tx_on}, 4'hf);
    chk(takes, 0);
  endtask
  task automatic t_silent();
    restart(1'b0);
    tick(20);
    chk({o_adv_supported, o_adv_enabled, o_adv_active}, 3'b100);
    chk(takes, 0);
  endtask
  task automatic t_verify();
    answer <= 1'b1;
    restart(1'b1);
    for (int i = 0; i < 40 && o_adv_active !== 1'b1; i++) tick(1);
    chk({o_adv_supported, o_adv_enabled, o_adv_active, o_preempt_tx_on}, 4'hf);
    chk(takes, 1);
  endtask
  task automatic t_retry();
    answer <= 1'b0;
    stall <= 1'b1;
    restart(1'b1);
    tick(4);
    chk({o_adv_supported, o_adv_enabled, o_adv_active}, 3'b110);
    stall <= 1'b0;
    tick(90);
    chk(takes, 3);
    chk({o_adv_supported, o_adv_enabled, o_adv_active}, 3'b100);
  endtask
  task automatic t_frag();
    for (int c = 0; c < 4; c++) begin
      i_min_frag_code <= c[1:0];
      i_tx_crc <= 32'h1234abcd + c;
      i_tx_frag_last <= c[0];
      tick(2);
      chk(o_min_frag_bytes, 32'((c + 1) * 64));
      chk(o_tx_mcrc, (32'h1234abcd + c) ^ (c[0] ? 32'h0 : 32'h0000ffff));
    end
  endtask
  task automatic t_count();
    for (int s = 0; s < 6; s++) begin
      repeat (s + 2) begin
        ev <= 6'h01 << s;
        tick(1);
        ev <= 6'h00;
        tick(1);
      end
      rd_cnt(s[2:0], 1);
      chk(o_cnt_data, 32'(s + 2));
      rd_cnt(s[2:0], 2);
      chk(o_cnt_data, 32'h0);
    end
    rd_cnt(3'h7, 1);
    chk(o_cnt_data, 32'h0);
  endtask
  initial begin
    tick(4);
    i_reset <= 1'b0;
    // accept rises at the first edge after release; look one edge later
    tick(2);
    chk(o_rx_preempt_accept, 1'b1);
    i_preempt_en <= 1'b1;
    t_force();
    t_silent();
    t_verify();
    t_retry();
    t_frag();
    t_count();
    conclude();
  end
endmodule
